// file: pwt_top.sv
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module pwt_top (
   input  wire logic                    i_clk,
   input  wire logic                    i_reset_n,
   input  wire logic [pwt_pkg::AW-1:0]  i_addr,
   input  wire logic [pwt_pkg::DW-1:0]  i_wdata,
   input  wire logic                    i_wr,
   input  wire logic                    i_rd,
   output logic      [pwt_pkg::DW-1:0]  o_rdata,
   output logic                         o_irq,
   output logic      [pwt_pkg::NCH-1:0] o_pwm
);
   import pwt_pkg::*;

   // ****************************************************
   // State
   // ****************************************************
   typedef struct packed {
      logic [DW-1:0]                  ppr;
      logic [DW-1:0]                  csr;
      logic [DW-1:0]                  pcr;
      logic [NCH-1:0][CW-1:0]         reload;
      logic [NCH-1:0][CW-1:0]         compare;
      logic [NCH-1:0]                 ier;
      logic [NCH-1:0]                 pend;
      logic [NGRP-1:0][PRE_W-1:0]     pre_cnt;
      logic [NGRP-1:0][DIV_W-1:0]     div_cnt;
      logic [NGRP-1:0][PRE_W-1:0]     gap_cnt;
      logic [NGRP-1:0]                dz_lvl;
      logic [NCH-1:0]                 pwm;
      logic                           irq;
      logic [DW-1:0]                  rdata;
   } pwt_top_st_t;
   pwt_top_st_t q;
   pwt_top_st_t n;

   logic [NGRP-1:0]         pre_tick;
   logic [NCH-1:0]          ch_tick;
   logic [NCH-1:0][DIV_W:0] ch_mask;
   logic [NCH-1:0][CW-1:0]  ch_count;
   logic [NCH-1:0]          ch_pwm;
   logic [NCH-1:0]          ch_zero;
   logic [NCH-1:0]          ch_level;
   logic [NCH-1:0]          clr;
   logic [NGRP-1:0]         dz_src;
   logic [NCH-1:0]          dz_pin;

   // ****************************************************
   // Clock generation
   // ****************************************************

   // Prescaler ticks; a zero setting gives no tick at all
   always_comb
   begin
      for (int g = 0; g < NGRP; g++)
      begin
         // R2: one prescaler per group
         // R20: divide by setting plus one
         pre_tick[g] = (q.ppr[g*PRE_W +: PRE_W] != '0)
            && (q.pre_cnt[g] == q.ppr[g*PRE_W +: PRE_W]);
      end
   end

   // Channel PWM clock, a single-cycle enable pulse
   always_comb
   begin
      for (int c = 0; c < NCH; c++)
      begin
         // R3: five rates from the divider
         // R21: select code decode
         ch_mask[c] = sel_mask(q.csr[c*CLKSEL_STEP +: CLKSEL_W]);
         ch_tick[c] = pre_tick[c/2] && ch_mask[c][DIV_W]
            && ((q.div_cnt[c/2] & ch_mask[c][DIV_W-1:0])
                == ch_mask[c][DIV_W-1:0]);
      end
   end

   // ****************************************************
   // Channels
   // ****************************************************

   // R1: four channels, two per group
   // R17: all on the one clock
   for (genvar c = 0; c < NCH; c++)
   begin : g_ch
      localparam int EN = ctrl_base(c);
      pwt_chan u_chan (
         .i_clk     (i_clk),
         .i_reset_n (i_reset_n),
         .i_tick    (ch_tick[c]),
         .i_enable  (q.pcr[EN]),
         .i_toggle  (q.pcr[EN + CTRL_TOG]),
         .i_reload  (q.reload[c]),
         .i_compare (q.compare[c]),
         .o_count   (ch_count[c]),
         .o_pwm     (ch_pwm[c]),
         .o_zero    (ch_zero[c])
      );
   end

   // Channel levels after the optional inverter
   always_comb
   begin
      for (int c = 0; c < NCH; c++)
      begin
         // R25: complement when inverter on
         ch_level[c] = ch_pwm[c] ^ q.pcr[ctrl_base(c) + CTRL_INV];
      end
   end

   // ****************************************************
   // Dead zone
   // ****************************************************

   // The first channel of each group feeds the generator;
   // each pin waits out the gap before going high
   always_comb
   begin
      for (int g = 0; g < NGRP; g++)
      begin
         dz_src[g]       = ch_level[2*g];
         // R8: gap before each rising edge
         dz_pin[2*g]     = q.dz_lvl[g] && (q.gap_cnt[g] == '0);
         dz_pin[2*g + 1] = !q.dz_lvl[g] && (q.gap_cnt[g] == '0);
      end
   end

   // Write-one-to-clear mask for pending requests
   always_comb
   begin
      clr = '0;
      if (i_wr && i_addr == OFS_PENDING)
         clr = i_wdata[NCH-1:0];
   end

   // ****************************************************
   // Next state
   // ****************************************************
   always_comb
   begin
      n       = q;
      n.rdata = '0;

      // Register writes; buffers may change at any time
      if (i_wr)
      begin
         if (i_addr == OFS_PRESCALE)
            n.ppr = i_wdata;
         if (i_addr == OFS_CLKSEL)
            n.csr = i_wdata & CLKSEL_WMASK;
         if (i_addr == OFS_CTRL)
            n.pcr = i_wdata & CTRL_WMASK;
         if (i_addr == OFS_IRQ_EN)
            n.ier = i_wdata[NCH-1:0];
         for (int c = 0; c < NCH; c++)
         begin
            // R9: writes land in buffers only
            if (i_addr == ch_addr(c, SUB_RELOAD))
               n.reload[c] = i_wdata[CW-1:0];
            if (i_addr == ch_addr(c, SUB_COMPARE))
               n.compare[c] = i_wdata[CW-1:0];
         end
      end

      // R24: set wins over clear
      n.pend = (q.pend & ~clr) | ch_zero;
      n.irq  = |(n.pend & n.ier);

      // Prescaler and divider counters
      for (int g = 0; g < NGRP; g++)
      begin
         // R20: restart count at the tick
         if (pre_tick[g] || q.ppr[g*PRE_W +: PRE_W] == '0)
            n.pre_cnt[g] = '0;
         else
            n.pre_cnt[g] = q.pre_cnt[g] + 1'b1;
         if (pre_tick[g])
            n.div_cnt[g] = q.div_cnt[g] + 1'b1;
      end

      // Dead-zone sequencing, stepped only by the PWM clock
      for (int g = 0; g < NGRP; g++)
      begin
         // R6: group PWM clock drives it
         if (ch_tick[2*g])
         begin
            if (dz_src[g] != q.dz_lvl[g])
            begin
               n.dz_lvl[g]  = dz_src[g];
               n.gap_cnt[g] = q.ppr[GAP_POS + g*PRE_W +: PRE_W];
            end
            else if (q.gap_cnt[g] != '0)
               n.gap_cnt[g] = q.gap_cnt[g] - 1'b1;
         end
      end

      // Output pins
      for (int g = 0; g < NGRP; g++)
      begin
         // R7: dead zone replaces both pins
         if (q.pcr[CTRL_DZ_POS + g])
         begin
            n.pwm[2*g]     = dz_pin[2*g];
            n.pwm[2*g + 1] = dz_pin[2*g + 1];
         end
         else
         begin
            n.pwm[2*g]     = ch_level[2*g];
            n.pwm[2*g + 1] = ch_level[2*g + 1];
         end
      end

      // Reads answer in the following cycle; unmapped read zero
      if (i_rd)
      begin
         if (i_addr == OFS_PRESCALE)
            n.rdata = q.ppr;
         if (i_addr == OFS_CLKSEL)
            n.rdata = q.csr;
         if (i_addr == OFS_CTRL)
            n.rdata = q.pcr;
         if (i_addr == OFS_IRQ_EN)
            n.rdata[NCH-1:0] = q.ier;
         if (i_addr == OFS_PENDING)
            n.rdata[NCH-1:0] = q.pend;
         for (int c = 0; c < NCH; c++)
         begin
            if (i_addr == ch_addr(c, SUB_RELOAD))
               n.rdata[CW-1:0] = q.reload[c];
            if (i_addr == ch_addr(c, SUB_COMPARE))
               n.rdata[CW-1:0] = q.compare[c];
            // R15: live counter readback
            if (i_addr == ch_addr(c, SUB_READBACK))
               n.rdata[CW-1:0] = ch_count[c];
         end
      end
   end

   // ****************************************************
   // State register
   // ****************************************************
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         q <= '0;
      else
         q <= n;
   end

   // All outputs leave straight from flops
   assign o_rdata = q.rdata;
   assign o_irq   = q.irq;
   assign o_pwm   = q.pwm;

   // ****************************************************
   // Checks
   // ****************************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);

   irq_raise_a: assert property ( // R10
      ch_zero[0] && q.ier[0] && !i_wr |=> o_irq)
      else $error("zero event did not raise interrupt");

   set_wins_a: assert property ( // R24
      ch_zero[1] |=> q.pend[1])
      else $error("pending set lost against clear");

   pend_clear_a: assert property ( // R24
      i_wr && i_addr == OFS_PENDING && i_wdata[0] && !ch_zero[0]
      |=> !q.pend[0])
      else $error("pending bit not cleared");

   irq_masked_a: assert property ( // R24
      q.ier == '0 && !i_wr |=> !o_irq)
      else $error("interrupt with all enables off");

   read_back_a: assert property ( // R15
      i_rd && i_addr == ch_addr(2, SUB_READBACK)
      |=> o_rdata[CW-1:0] == $past(ch_count[2]) ##1 o_rdata == '0
          || $past(i_rd))
      else $error("readback mismatch");

   read_idle_a: assert property (
      !i_rd |=> o_rdata == '0)
      else $error("read data outside read answer cycle");

   dz_exclusive_a: assert property ( // R7
      q.pcr[CTRL_DZ_POS] && $past(q.pcr[CTRL_DZ_POS])
      |-> !(o_pwm[0] && o_pwm[1]))
      else $error("both dead-zone pins high");

   pre_stop_a: assert property ( // R20
      q.ppr[PRE_W-1:0] == '0 |-> !pre_tick[0] && !ch_tick[0])
      else $error("prescaler ran with zero setting");

   pre_period_a: assert property ( // R20
      pre_tick[1] && q.ppr[2*PRE_W-1:PRE_W] == 8'h01 && !i_wr
      |=> !pre_tick[1] ##1 (pre_tick[1] || $past(i_wr)))
      else $error("prescaler period wrong");

   irq_seen_c: cover property (o_irq && q.pend[3]);
   dz_gap_c: cover property (q.pcr[CTRL_DZ_POS] && q.gap_cnt[0] != '0);
   clr_race_c: cover property (clr[0] && ch_zero[0]);
endmodule : pwt_top

// file: pwt_chan.sv
// Notes on behaviour
// R1: Four channels in two groups, own interrupts.
// R2: Each group shares one 8-bit prescaler.
// R3: Five clock rates: 1, 1/2, 1/4, 1/8, 1/16.
// R4: 16-bit down counter and comparator per channel.
// R5: Output level changes when count equals compare.
// R6: Dead-zone logic clocked by group PWM clock.
// R7: Dead-zone enable replaces both group outputs.
// R8: 8-bit gap delays each rising output edge.
// R9: Reload and compare are double-buffered.
// R10: Counter reaching zero raises channel request.
// R11: Toggle mode reloads and continues at zero.
// R12: One-shot mode stops with one request.
// R13: Zero reload halts counter at zero.
// R14: Clearing enable stops the counter at once.
// R15: Counter value readable per channel.
// R16: New compare takes effect next period.
// R17: Whole block runs from one clock.
// R18: Software programs setup in fixed order.
// R19: Software stops by zero reload, then disables.
// R20: Prescaler divides by setting plus one, zero stops.
// R21: Select codes 000..100 give 2,4,8,16,1.
// R22: Period is reload plus one PWM cycles.
// R23: Duty is compare plus one PWM cycles.
// R24: Requests pend until cleared; enabled ones interrupt.
// R25: Inverter drives complement of channel waveform.
package pwt_pkg;
   // ****************************************************
   // Sizes and register map
   // ****************************************************
   localparam int NCH   = 4;
   localparam int NGRP  = 2;
   localparam int CW    = 16;
   localparam int AW    = 8;
   localparam int DW    = 32;
   localparam int PRE_W = 8;
   localparam int DIV_W = 4;
   localparam logic [AW-1:0] OFS_PRESCALE = 8'h00;
   localparam logic [AW-1:0] OFS_CLKSEL   = 8'h04;
   localparam logic [AW-1:0] OFS_CTRL     = 8'h08;
   localparam logic [AW-1:0] OFS_CH_BASE  = 8'h0c;
   localparam logic [AW-1:0] OFS_CH_STEP  = 8'h0c;
   localparam logic [AW-1:0] SUB_RELOAD   = 8'h00;
   localparam logic [AW-1:0] SUB_COMPARE  = 8'h04;
   localparam logic [AW-1:0] SUB_READBACK = 8'h08;
   localparam logic [AW-1:0] OFS_IRQ_EN   = 8'h3c;
   localparam logic [AW-1:0] OFS_PENDING  = 8'h40;
   // Writable bits; the rest read as zero
   localparam logic [DW-1:0] CTRL_WMASK   = 32'h000d_dd3d;
   localparam logic [DW-1:0] CLKSEL_WMASK = 32'h0000_7777;
   // ****************************************************
   // Field positions
   // ****************************************************
   localparam int CTRL_INV    = 2;
   localparam int CTRL_TOG    = 3;
   localparam int CTRL_DZ_POS = 4;
   localparam int CLKSEL_STEP = 4;
   localparam int CLKSEL_W    = 3;
   localparam int GAP_POS     = 16;
   localparam logic [CLKSEL_W-1:0] SEL_DIV2  = 3'h0;
   localparam logic [CLKSEL_W-1:0] SEL_DIV4  = 3'h1;
   localparam logic [CLKSEL_W-1:0] SEL_DIV8  = 3'h2;
   localparam logic [CLKSEL_W-1:0] SEL_DIV16 = 3'h3;
   localparam logic [CLKSEL_W-1:0] SEL_DIV1  = 3'h4;
   typedef enum logic [1:0] {
      CH_IDLE = 2'b01,
      CH_RUN  = 2'b10
   } pwt_chst_t;
   // Enable bit of a channel's control field
   function automatic int ctrl_base(input int c);
      return (c == 0) ? 0 : 4 + 4 * c;
   endfunction : ctrl_base
   // Byte address of a per-channel register
   function automatic logic [AW-1:0] ch_addr(input int c,
                                             input logic [AW-1:0] sub);
      return OFS_CH_BASE + AW'(c) * OFS_CH_STEP + sub;
   endfunction : ch_addr
   // Divider mask: {valid, low divider bits that must be ones}
   function automatic logic [DIV_W:0] sel_mask(
      input logic [CLKSEL_W-1:0] sel);
      logic [DIV_W:0] m;
      m = '0;
      unique case (sel)
         SEL_DIV2:  m = 5'h11;
         SEL_DIV4:  m = 5'h13;
         SEL_DIV8:  m = 5'h17;
         SEL_DIV16: m = 5'h1f;
         SEL_DIV1:  m = 5'h10;
         default:   m = '0;
      endcase
      return m;
   endfunction : sel_mask
endpackage : pwt_pkg

`timescale 1ns/1ns
module pwt_chan (
   input  wire logic                   i_clk,
   input  wire logic                   i_reset_n,
   input  wire logic                   i_tick,
   input  wire logic                   i_enable,
   input  wire logic                   i_toggle,
   input  wire logic [pwt_pkg::CW-1:0] i_reload,
   input  wire logic [pwt_pkg::CW-1:0] i_compare,
   output logic      [pwt_pkg::CW-1:0] o_count,
   output logic                        o_pwm,
   output logic                        o_zero
);
   import pwt_pkg::*;
   typedef struct packed {
      pwt_chst_t     st;
      logic          en_q;
      logic [CW-1:0] count;
      logic [CW-1:0] cmp_act;
      logic          pwm;
      logic          zero;
   } pwt_chan_st_t;
   pwt_chan_st_t q;
   pwt_chan_st_t n;

   // Counter sequencing; buffers copy in only at period start
   always_comb
   begin
      n      = q;
      n.zero = 1'b0;
      n.en_q = i_enable;
      unique case (q.st)
         CH_IDLE:
         begin
            // R9: load on enable edge
            if (i_enable && !q.en_q && i_reload != '0)
            begin
               n.st      = CH_RUN;
               n.count   = i_reload;
               n.cmp_act = i_compare;
            end
         end
         CH_RUN:
         begin
            // R14: stop immediately
            if (!i_enable)
               n.st = CH_IDLE;
            else if (i_tick)
            begin
               // R4: count down per tick
               // R22: reload down to zero
               if (q.count != '0)
                  n.count = q.count - 1'b1;
               else
               begin
                  // R10: zero request
                  n.zero = 1'b1;
                  // R11: toggle reload
                  // R16: compare for next period
                  if (i_toggle && i_reload != '0)
                  begin
                     n.count   = i_reload;
                     n.cmp_act = i_compare;
                  end
                  // R12: one-shot stop
                  // R13: zero reload halts
                  else
                     n.st = CH_IDLE;
               end
            end
         end
      endcase
      // R5: high from compare match down to zero
      // R23: duty is compare plus one ticks
      n.pwm = (n.st == CH_RUN) && (n.count <= n.cmp_act);
   end

   // State register
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         q    <= '0;
         q.st <= CH_IDLE;
      end
      else
         q <= n;
   end

   assign o_count = q.count;
   assign o_pwm   = q.pwm;
   assign o_zero  = q.zero;

   // ****************************************************
   // Checks
   // ****************************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);

   count_step_a: assert property ( // R4
      q.st == CH_RUN && i_enable && i_tick && q.count != '0
      |=> o_count == $past(o_count) - 1'b1)
      else $error("counter did not step down");
   oneshot_end_a: assert property ( // R12
      q.st == CH_RUN && i_enable && i_tick && q.count == '0 && !i_toggle
      |=> o_zero && q.st == CH_IDLE ##1 !o_zero)
      else $error("one-shot did not stop with one request");
   disable_stop_a: assert property ( // R14
      q.st == CH_RUN && !i_enable |=> q.st == CH_IDLE && !o_pwm)
      else $error("channel kept running after disable");
   reload_wrap_a: assert property ( // R11
      q.st == CH_RUN && i_enable && i_tick && q.count == '0 && i_toggle
      && i_reload != '0 |=> o_count == $past(i_reload))
      else $error("toggle mode did not reload");
   toggle_wrap_c: cover property (o_zero && q.st == CH_RUN);
   oneshot_done_c: cover property (o_zero && q.st == CH_IDLE);
endmodule : pwt_chan

// file: pwt_load.sv
`timescale 1ns/1ns
// ****************************************************
// Power stage load: times the pulses on one drive pin
// ****************************************************
module pwt_load (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_drive,
   output logic      [15:0] o_rises,
   output logic      [15:0] o_period,
   output logic      [15:0] o_high
);
   logic        prev;
   logic [15:0] since_rise;

   // Widths in clocks; a pin with no edges keeps the last figures
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         prev       <= 1'b0;
         since_rise <= 16'h0000;
         o_rises    <= 16'h0000;
         o_period   <= 16'h0000;
         o_high     <= 16'h0000;
      end
      else
      begin
         prev       <= i_drive;
         since_rise <= since_rise + 16'h0001;
         if (i_drive && !prev)
         begin
            o_rises    <= o_rises + 16'h0001;
            o_period   <= since_rise;
            since_rise <= 16'h0001;
         end
         if (!i_drive && prev)
            o_high <= since_rise;
      end
   end
endmodule : pwt_load

// file: test_four_channel_pwm_timer.sv
`timescale 1ns/1ns
module test_four_channel_pwm_timer;
   import pwt_pkg::*;
   typedef struct {
      int          ch;
      logic [31:0] ppr;
      logic [2:0]  sel;
      logic [15:0] rel;
      logic [15:0] cmp;
      logic [4:0]  mode;
      logic [15:0] per;
      logic [15:0] hi;
   } pwt_row_t;
   logic           i_clk;
   logic           i_reset_n;
   logic [AW-1:0]  i_addr;
   logic [DW-1:0]  i_wdata;
   logic           i_wr;
   logic           i_rd;
   logic [DW-1:0]  o_rdata;
   logic           o_irq;
   logic [NCH-1:0] o_pwm;
   logic [15:0]    rises [NCH];
   logic [15:0]    period [NCH];
   logic [15:0]    high [NCH];
   logic [AW-1:0]  ma [8];
   logic [DW-1:0]  mx [8];
   pwt_row_t       rows [6];
   logic [31:0]    d;
   logic [31:0]    d2;
   int             errors;
   int             total_checks;
   int             overlap = 0;
   int             r0;
   int             k;

   // ****************************************************
   // Design, loads and clock
   // ****************************************************
   pwt_top uut (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_addr    (i_addr),
      .i_wdata   (i_wdata),
      .i_wr      (i_wr),
      .i_rd      (i_rd),
      .o_rdata   (o_rdata),
      .o_irq     (o_irq),
      .o_pwm     (o_pwm)
   );
   for (genvar g = 0; g < NCH; g++)
   begin : g_load
      pwt_load u_load (
         .i_clk     (i_clk),
         .i_reset_n (i_reset_n),
         .i_drive   (o_pwm[g]),
         .o_rises   (rises[g]),
         .o_period  (period[g]),
         .o_high    (high[g])
      );
   end
   initial
   begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   // Both half-bridge switches on at once would short the supply
   always @(posedge i_clk)
      if (o_pwm[0] && o_pwm[1])
         overlap <= overlap + 1;

   // ****************************************************
   // Shared tasks
   // ****************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic summarize();
      if (errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
      @(posedge i_clk);
      i_addr  <= a;
      i_wdata <= v;
      i_wr    <= 1'b1;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
      @(posedge i_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      @(negedge i_clk);
      v = o_rdata;
   endtask : rd
   function automatic logic [AW-1:0] reg_of(input int c, input int sub);
      return 8'h0c + 8'(12 * c + sub);
   endfunction : reg_of
   function automatic int cbit(input int c);
      return (c == 0) ? 0 : 4 + 4 * c;
   endfunction : cbit
   task automatic start(input int c, input logic [31:0] ppr,
                        input logic [2:0] sel, input logic [15:0] rel,
                        input logic [15:0] cmp, input logic [4:0] mode);
      wr(OFS_CTRL, 32'h0000_0000);
      wr(OFS_CLKSEL, 32'(sel) << (4 * c));
      wr(OFS_PRESCALE, ppr);
      wr(reg_of(c, SUB_COMPARE), 32'(cmp));
      wr(reg_of(c, SUB_RELOAD), 32'(rel));
      wr(OFS_CTRL, 32'(mode | 5'h01) << cbit(c));
   endtask : start
   // Bounded wait for rising edges on one pin
   task automatic wait_rises(input int c, input int n);
      int goal;
      goal = int'(rises[c]) + n;
      for (int j = 0; j < 2000 && int'(rises[c]) < goal; j++)
         @(posedge i_clk);
      if (int'(rises[c]) < goal)
      begin
         errors++;
         $display("BAD %0t no pulses on pin %0d", $time, c);
         summarize();
      end
   endtask : wait_rises

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial
   begin
      i_reset_n = 1'b0;
      i_addr = 8'h00;
      i_wdata = 32'h0000_0000;
      i_wr = 1'b0;
      i_rd = 1'b0;
      errors = 0;
      total_checks = 0;
      // Pulse clocks: period (R+1)*(P+1)*div, high (C+1)*(P+1)*div, or (R-C)*(P+1)*div with the inverter on
      rows = '{
      '{0, 32'h0000_0001, 3'h4, 16'h0004, 16'h0001, 5'h08, 16'h000a, 16'h0004},
      '{0, 32'h0000_0001, 3'h0, 16'h0004, 16'h0001, 5'h08, 16'h0014, 16'h0008},
      '{1, 32'h0000_0002, 3'h1, 16'h0002, 16'h0000, 5'h08, 16'h0024, 16'h000c},
      '{2, 32'h0000_0100, 3'h2, 16'h0001, 16'h0000, 5'h08, 16'h0020, 16'h0010},
      '{3, 32'h0000_0100, 3'h3, 16'h0001, 16'h0000, 5'h08, 16'h0040, 16'h0020},
      '{0, 32'h0000_0001, 3'h4, 16'h0004, 16'h0001, 5'h0c, 16'h000a, 16'h0006}
      };
      ma = '{OFS_PRESCALE, OFS_CLKSEL, OFS_CTRL, OFS_IRQ_EN, 8'h14, 8'h44,
             OFS_PENDING, OFS_CH_BASE};
      mx = '{32'hffff_ffff, 32'h0000_7777, 32'h000d_dd3d, 32'h0000_000f,
             32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_ffff};
      repeat (10) @(posedge i_clk);
      i_reset_n <= 1'b1;
      // Rates, groups, duty and inverter from the table
      foreach (rows[i])
      begin
         start(rows[i].ch, rows[i].ppr, rows[i].sel, rows[i].rel,
               rows[i].cmp, rows[i].mode);
         wait_rises(rows[i].ch, 3);
         check(32'(period[rows[i].ch]), 32'(rows[i].per), "period");
         check(32'(high[rows[i].ch]), 32'(rows[i].hi), "duty");
      end
      // Second reset in mid-run clears everything
      i_reset_n <= 1'b0;
      repeat (10) @(posedge i_clk);
      check(32'(o_pwm), 32'h0000_0000, "pins in reset");
      i_reset_n <= 1'b1;
      for (k = 0; k <= 8'h44; k += 4)
      begin
         rd(8'(k), d);
         check(d, 32'h0000_0000, "reset value");
      end
      // Writable bits, read-only and unmapped places
      foreach (ma[i])
      begin
         wr(ma[i], 32'hffff_ffff);
         rd(ma[i], d);
         check(d, mx[i], "register mask");
      end
      wr(OFS_CTRL, 32'h0000_0000);
      start(0, 32'h0000_0000, 3'h4, 16'h0009, 16'h0001, 5'h08);
      repeat (30) @(posedge i_clk);
      rd(reg_of(0, SUB_READBACK), d);
      check(d, 32'h0000_0009, "stopped prescaler");
      // compare written mid-period waits for the next one
      start(0, 32'h0000_0001, 3'h4, 16'h0009, 16'h0001, 5'h08);
      wait_rises(0, 2);
      repeat (6) @(posedge i_clk);
      wr(reg_of(0, SUB_COMPARE), 32'h0000_0005);
      wait_rises(0, 1);
      repeat (6) @(posedge i_clk);
      check(32'(high[0]), 32'h0000_0004, "old duty");
      wait_rises(0, 1);
      repeat (14) @(posedge i_clk);
      check(32'(high[0]), 32'h0000_000c, "new duty");
      // stop by zero reload, then disable
      wr(reg_of(0, SUB_RELOAD), 32'h0000_0000);
      d = 32'hffff_ffff;
      for (k = 0; k < 50 && d !== 32'h0000_0000; k++)
         rd(reg_of(0, SUB_READBACK), d);
      check(d, 32'h0000_0000, "count at zero");
      r0 = int'(rises[0]);
      repeat (60) @(posedge i_clk);
      check(32'(rises[0]), 32'(r0), "pulses after halt");
      wr(OFS_CTRL, 32'h0000_0000);
      // clearing enable freezes the count at once
      start(0, 32'h0000_0001, 3'h4, 16'h00c8, 16'h00c7, 5'h08);
      repeat (20) @(posedge i_clk);
      wr(OFS_CTRL, 32'h0000_0000);
      rd(reg_of(0, SUB_READBACK), d);
      repeat (10) @(posedge i_clk);
      rd(reg_of(0, SUB_READBACK), d2);
      check(d2, d, "frozen count");
      check(32'(d != 32'h0 && d < 32'h00c8), 32'h1, "count moved");
      check(32'(o_pwm[0]), 32'h0000_0000, "pin low");
      // one-shot raises one request; enable and clear
      // Channel 0 left requests pending from the runs above
      wr(OFS_PENDING, 32'h0000_000f);
      wr(OFS_IRQ_EN, 32'h0000_0002);
      start(1, 32'h0000_0001, 3'h4, 16'h0003, 16'h0000, 5'h00);
      for (k = 0; k < 100 && o_irq !== 1'b1; k++)
         @(posedge i_clk);
      check(32'(o_irq), 32'h0000_0001, "irq raised");
      rd(OFS_PENDING, d);
      check(d, 32'h0000_0002, "pending");
      rd(reg_of(1, SUB_READBACK), d);
      check(d, 32'h0000_0000, "one-shot stop");
      wr(OFS_PENDING, 32'h0000_0002);
      repeat (40) @(posedge i_clk);
      check(32'(o_irq), 32'h0000_0000, "irq cleared");
      rd(OFS_PENDING, d);
      check(d, 32'h0000_0000, "single request");
      // Masked request pends but stays off the line
      wr(OFS_IRQ_EN, 32'h0000_0000);
      wr(OFS_CTRL, 32'h0000_0000);
      wr(OFS_CTRL, 32'h0000_0100);
      repeat (30) @(posedge i_clk);
      check(32'(o_irq), 32'h0000_0000, "masked irq");
      rd(OFS_PENDING, d);
      check(d, 32'h0000_0002, "masked pending");
      // dead zone on group 0 with a two-tick gap
      start(0, 32'h0002_0001, 3'h4, 16'h0009, 16'h0005, 5'h18);
      r0 = overlap;
      wait_rises(0, 3);
      check(32'(high[0]), 32'h0000_0008, "gap on pin 0");
      check(32'(high[1]), 32'h0000_0004, "gap on pin 1");
      check(32'(overlap), 32'(r0), "both pins high");
      summarize();
   end
endmodule : test_four_channel_pwm_timer
